// *** core/interrupt_vector_mapper.sv ***
// Operation
// - Twenty-six vectors; vectors 1-25 each from one peripheral.
// - Peripheral condition sets its event flag.
// - Software-writable enable bit per source.
// - Request needs both enable and flag.
// - Request holds until flag is cleared.
// - Global enable gates every maskable request.
// - Vector 0 reset; vector 1 scan NMI.
// - Vectors 2-5: voltage monitor, port changes.
// - Vectors 6, 7: counter and periodic timer.
// - Vectors 8-12: timer A overflow, underflow, compares.
// - Vectors 13-16: timer B, timer D, comparator.
// - Vectors 17, 18: converter result, window.
// - Vectors 19-21: two-wire target, controller, serial.
// - Vectors 22-24: receive, data empty, transmit.
// - Vector 25: nonvolatile memory controller.
`timescale 1ns/100ps
module interrupt_vector_mapper (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ivm_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [ivm_pkg::DATA_W-1:0] wb_dat_i,
   output logic [ivm_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Peripheral event pulses
   input wire logic scan_checksum_nonmaskable,
   input wire logic voltage_level_monitor_req,
   input wire logic port_a_pin_change_req,
   input wire logic port_b_pin_change_req,
   input wire logic port_c_pin_change_req,
   input wire logic rtc_counter_req,
   input wire logic periodic_timer_req,
   input wire logic timer_a_overflow,
   input wire logic timer_a_low_underflow,
   input wire logic timer_a_high_underflow,
   input wire logic timer_a_compare_0,
   input wire logic timer_a_compare_1,
   input wire logic timer_a_compare_2,
   input wire logic timer_b_req,
   input wire logic timer_d_overflow,
   input wire logic timer_d_trigger,
   input wire logic comparator_req,
   input wire logic converter_result_ready,
   input wire logic converter_window_compare,
   input wire logic two_wire_target_req,
   input wire logic two_wire_controller_req,
   input wire logic serial_peripheral_req,
   input wire logic serial_receive_complete,
   input wire logic serial_data_reg_empty,
   input wire logic serial_transmit_complete,
   input wire logic nonvolatile_ready_req,
   // Core request
   output logic core_req,
   output logic core_nmi,
   output logic [ivm_pkg::VEC_W-1:0] core_vector,
   // Block interrupt
   output logic irq
);
   localparam int NV = ivm_pkg::NUM_VECTORS;

   function automatic logic [ivm_pkg::VEC_W-1:0] first_active(input logic [NV-1:0] m);
      logic [ivm_pkg::VEC_W-1:0] v;
      v = '0;
      for (int i = NV - 1; i >= 0; i--) begin
         if (m[i]) begin
            v = ivm_pkg::VEC_W'(i);
         end
      end
      return v;
   endfunction : first_active

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   logic [ivm_pkg::CTL_W-1:0] control_r;
   logic [NV-1:0] event_flag_register_r;
   logic [NV-1:0] source_enable_register_r;
   logic [ivm_pkg::IRQ_W-1:0] irq_status_r;
   logic [ivm_pkg::IRQ_W-1:0] irq_enable_r;
   logic ack_r;
   logic [ivm_pkg::DATA_W-1:0] rdata_r;
   logic core_req_r;
   logic core_nmi_r;
   logic [ivm_pkg::VEC_W-1:0] core_vector_r;

   logic [NV-1:0] set_vec;
   logic [NV-1:0] flag_clr;
   logic [NV-1:0] pending;
   logic [NV-1:0] eligible;
   logic wr_go;
   logic rd_go;
   logic global_en;
   logic split_mode;
   logic [31:0] wdat_m;
   logic [ivm_pkg::DATA_W-1:0] rdata_nxt;
   logic [31:0] enable_m;
   logic [31:0] control_m;
   logic [31:0] irq_enable_m;

   assign global_en = control_r[ivm_pkg::CTL_GLOBAL_EN_BIT];
   assign split_mode = control_r[ivm_pkg::CTL_SPLIT_BIT];
   // A write commits on the edge where the master samples ack, as classic cycles expect
   assign wr_go = wb_cyc_i && wb_stb_i && ack_r && wb_we_i;
   assign rd_go = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;
   assign wdat_m = merge(32'h00000000, wb_dat_i, wb_sel_i);
   // Byte-merged values for the read-write registers, sliced where they are stored
   assign enable_m = merge(32'(source_enable_register_r), wb_dat_i, wb_sel_i);
   assign control_m = merge(32'(control_r), wb_dat_i, wb_sel_i);
   assign irq_enable_m = merge(32'(irq_enable_r), wb_dat_i, wb_sel_i);

   // Vector wiring; vector 0 is reset and never carries a flag
   always_comb begin
      set_vec = '0;
      set_vec[ivm_pkg::VEC_NMI] = scan_checksum_nonmaskable;
      set_vec[ivm_pkg::VEC_VLM] = voltage_level_monitor_req;
      set_vec[ivm_pkg::VEC_PORT_A] = port_a_pin_change_req;
      set_vec[ivm_pkg::VEC_PORT_A + 1] = port_b_pin_change_req;
      set_vec[ivm_pkg::VEC_PORT_A + 2] = port_c_pin_change_req;
      set_vec[ivm_pkg::VEC_RTC_COUNTER_REQ] = rtc_counter_req;
      set_vec[ivm_pkg::VEC_PERIODIC_TIMER_REQ] = periodic_timer_req;
      // Split mode swaps the overflow source for the low-half underflow
      set_vec[ivm_pkg::VEC_TA_OVF] = split_mode ? timer_a_low_underflow
                                                : timer_a_overflow;
      set_vec[ivm_pkg::VEC_TA_HUNF] = timer_a_high_underflow;
      set_vec[ivm_pkg::VEC_TA_CMP0] = timer_a_compare_0;
      set_vec[ivm_pkg::VEC_TA_CMP0 + 1] = timer_a_compare_1;
      set_vec[ivm_pkg::VEC_TA_CMP0 + 2] = timer_a_compare_2;
      set_vec[ivm_pkg::VEC_TB] = timer_b_req;
      set_vec[ivm_pkg::VEC_TD_OVF] = timer_d_overflow;
      set_vec[ivm_pkg::VEC_TD_TRIG] = timer_d_trigger;
      set_vec[ivm_pkg::VEC_AC] = comparator_req;
      set_vec[ivm_pkg::VEC_ADC_RES] = converter_result_ready;
      set_vec[ivm_pkg::VEC_ADC_WCMP] = converter_window_compare;
      set_vec[ivm_pkg::VEC_TWI_TGT] = two_wire_target_req;
      set_vec[ivm_pkg::VEC_TWI_CTL] = two_wire_controller_req;
      set_vec[ivm_pkg::VEC_SPI] = serial_peripheral_req;
      set_vec[ivm_pkg::VEC_SER_RXC] = serial_receive_complete;
      set_vec[ivm_pkg::VEC_SER_DRE] = serial_data_reg_empty;
      set_vec[ivm_pkg::VEC_SER_TXC] = serial_transmit_complete;
      set_vec[ivm_pkg::VEC_NVM] = nonvolatile_ready_req;
   end

   assign flag_clr = (wr_go && wb_adr_i == ivm_pkg::OFS_EVENT_FLAG) ? wdat_m[NV-1:0] : '0;

   // A new event wins over a write-one clear in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         event_flag_register_r <= ivm_pkg::FLAG_RESET;
      end else begin
         event_flag_register_r <= (event_flag_register_r & ~flag_clr) | set_vec;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         source_enable_register_r <= ivm_pkg::ENABLE_RESET;
      end else if (wr_go && wb_adr_i == ivm_pkg::OFS_SOURCE_ENABLE) begin
         // Vector 0 has no source, so its enable stays zero
         source_enable_register_r <= enable_m[NV-1:0] & ~26'h0000001;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         control_r <= ivm_pkg::CTL_RESET;
      end else if (wr_go && wb_adr_i == ivm_pkg::OFS_CONTROL) begin
         control_r <= control_m[ivm_pkg::CTL_W-1:0];
      end
   end

   assign pending = event_flag_register_r & source_enable_register_r;
   // The NMI bypasses the global enable; all others need it
   always_comb begin
      eligible = global_en ? pending : '0;
      eligible[ivm_pkg::VEC_NMI] = pending[ivm_pkg::VEC_NMI];
   end

   // Registered so the core sees a clean vector; one cycle of latency
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         core_req_r <= 1'b0;
         core_nmi_r <= 1'b0;
         core_vector_r <= '0;
      end else begin
         core_req_r <= |eligible;
         core_nmi_r <= eligible[ivm_pkg::VEC_NMI];
         core_vector_r <= first_active(eligible);
      end
   end

   assign core_req = core_req_r;
   assign core_nmi = core_nmi_r;
   assign core_vector = core_vector_r;

   // Block events: NMI raised, any request (NMI included) newly presented
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_status_r <= ivm_pkg::IRQ_RESET;
      end else begin
         irq_status_r <= (irq_status_r & ~((wr_go && wb_adr_i == ivm_pkg::OFS_IRQ_CLEAR)
                         ? wdat_m[ivm_pkg::IRQ_W-1:0] : ivm_pkg::IRQ_RESET))
                         | {(|eligible) && !core_req_r, eligible[ivm_pkg::VEC_NMI] && !core_nmi_r};
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_enable_r <= ivm_pkg::IRQ_RESET;
      end else if (wr_go && wb_adr_i == ivm_pkg::OFS_IRQ_ENABLE) begin
         irq_enable_r <= irq_enable_m[ivm_pkg::IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status_r & irq_enable_r);

   always_comb begin
      unique case (wb_adr_i)
         ivm_pkg::OFS_CONTROL: rdata_nxt = 32'(control_r);
         ivm_pkg::OFS_EVENT_FLAG: rdata_nxt = 32'(event_flag_register_r);
         ivm_pkg::OFS_SOURCE_ENABLE: rdata_nxt = 32'(source_enable_register_r);
         ivm_pkg::OFS_PENDING: rdata_nxt = 32'(pending);
         ivm_pkg::OFS_VECTOR: rdata_nxt = 32'(core_vector_r)
                                        | (32'(core_req_r) << ivm_pkg::VECREG_VALID_BIT)
                                        | (32'(core_nmi_r) << ivm_pkg::VECREG_NMI_BIT);
         ivm_pkg::OFS_IRQ_STATUS: rdata_nxt = 32'(irq_status_r);
         ivm_pkg::OFS_IRQ_ENABLE: rdata_nxt = 32'(irq_enable_r);
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Every access, mapped or not, is acknowledged one cycle after the strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
         if (rd_go) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;

   sequence strobe_s;
      wb_cyc_i && wb_stb_i && !ack_r;
   endsequence

   sequence ack_pulse_s;
      ack_r ##1 !ack_r;
   endsequence

   bus_ack_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      strobe_s |=> ack_pulse_s) else $error("ack not a single pulse after strobe");
   flag_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      timer_b_req |=> event_flag_register_r[ivm_pkg::VEC_TB])
      else $error("event did not set flag");
   flag_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      event_flag_register_r[ivm_pkg::VEC_SPI] && !flag_clr[ivm_pkg::VEC_SPI]
      |=> event_flag_register_r[ivm_pkg::VEC_SPI]) else $error("flag dropped");
   req_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      core_req_r |-> $past(pending) != '0) else $error("request without pending");
   global_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !global_en && !pending[ivm_pkg::VEC_NMI] |=> !core_req_r)
      else $error("request while globally off");
   nmi_vector_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      pending[ivm_pkg::VEC_NMI] |=> core_req_r && core_nmi_r
      && core_vector_r == ivm_pkg::VEC_W'(ivm_pkg::VEC_NMI))
      else $error("nmi not presented");
   lowest_first_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      global_en && pending[ivm_pkg::VEC_VLM] && !pending[ivm_pkg::VEC_NMI]
      |=> core_vector_r == ivm_pkg::VEC_W'(ivm_pkg::VEC_VLM))
      else $error("priority wrong");
   split_src_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      split_mode && timer_a_low_underflow
      |=> event_flag_register_r[ivm_pkg::VEC_TA_OVF])
      else $error("split underflow lost");
   reset_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !event_flag_register_r[ivm_pkg::VEC_RESET] && !source_enable_register_r[0])
      else $error("vector 0 flagged");
   serial_map_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      serial_data_reg_empty |=> event_flag_register_r[ivm_pkg::VEC_SER_DRE])
      else $error("serial mapping wrong");

   // Flags: every event lands, none rises alone, a clear without an event sticks
   flag_all_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (event_flag_register_r & $past(set_vec)) == $past(set_vec))
      else $error("event lost");
   flag_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (event_flag_register_r & ~$past(event_flag_register_r) & ~$past(set_vec)) == '0)
      else $error("flag rose without event");
   flag_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (event_flag_register_r & $past(flag_clr) & ~$past(set_vec)) == '0)
      else $error("cleared flag survived");

   // Register writes land at the ack edge and nowhere else
   sequence enable_wr_s;
      wr_go && wb_adr_i == ivm_pkg::OFS_SOURCE_ENABLE && wb_sel_i == 4'hF;
   endsequence

   sequence control_wr_s;
      wr_go && wb_adr_i == ivm_pkg::OFS_CONTROL && wb_sel_i[0];
   endsequence

   enable_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      enable_wr_s |=> source_enable_register_r == (NV'($past(wb_dat_i)) & ~26'h0000001))
      else $error("enable write lost");
   enable_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !(wr_go && wb_adr_i == ivm_pkg::OFS_SOURCE_ENABLE)
      |=> $stable(source_enable_register_r)) else $error("enable changed unwritten");
   control_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      control_wr_s |=> control_r == ivm_pkg::CTL_W'($past(wb_dat_i)))
      else $error("control write lost");
   read_data_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rd_go && wb_adr_i == ivm_pkg::OFS_PENDING |=> wb_dat_o == 32'($past(pending)))
      else $error("pending read wrong");

   // Request presentation, checked against the eligible set rather than the encoder
   req_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      core_req_r == ($past(eligible) != '0)) else $error("request not following");
   req_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      global_en && pending != '0 |=> core_req_r) else $error("request dropped");
   global_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !global_en |=> core_req_r == core_nmi_r) else $error("maskable request leaked");
   nmi_global_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      pending[ivm_pkg::VEC_NMI] && !global_en |=> core_nmi_r) else $error("nmi masked");
   nmi_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !pending[ivm_pkg::VEC_NMI] |=> !core_nmi_r) else $error("nmi without flag");
   vec_hit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      core_req_r |-> (($past(eligible) >> core_vector_r) & 26'h0000001) != '0)
      else $error("vector not active");
   vec_lowest_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      core_req_r |-> ($past(eligible) << (ivm_pkg::VEC_W'(NV) - core_vector_r)) == '0)
      else $error("lower vector skipped");
   vec_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !core_req_r |-> core_vector_r == '0) else $error("idle vector not zero");

   // Timer A vector 8 listens only to the source that the split setting picks
   sequence ta_idle_s;
      (split_mode ? !timer_a_low_underflow : !timer_a_overflow)
      && !event_flag_register_r[ivm_pkg::VEC_TA_OVF];
   endsequence

   ta_source_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      ta_idle_s |=> !event_flag_register_r[ivm_pkg::VEC_TA_OVF])
      else $error("timer A wrong source");

   // Block events; a set beats a clear in the same cycle
   sequence nmi_rise_s;
      eligible[ivm_pkg::VEC_NMI] && !core_nmi_r;
   endsequence

   nmi_event_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      nmi_rise_s |=> irq_status_r[ivm_pkg::IRQ_NMI_BIT]) else $error("nmi event lost");
   req_event_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (|eligible) && !core_req_r |=> irq_status_r[ivm_pkg::IRQ_REQ_BIT])
      else $error("request event lost");
endmodule : interrupt_vector_mapper

// *** core/ivm_pkg.sv ***
package ivm_pkg;
   localparam int NUM_VECTORS = 26;
   localparam int VEC_W = 5;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_EVENT_FLAG = 8'h04;
   localparam logic [7:0] OFS_SOURCE_ENABLE = 8'h08;
   localparam logic [7:0] OFS_PENDING = 8'h0C;
   localparam logic [7:0] OFS_VECTOR = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
   // Control register fields
   localparam int CTL_GLOBAL_EN_BIT = 0;
   localparam int CTL_SPLIT_BIT = 1;
   localparam int CTL_W = 2;
   localparam logic [1:0] CTL_RESET = 2'h0;
   // Vector register fields
   localparam int VECREG_VALID_BIT = 8;
   localparam int VECREG_NMI_BIT = 9;
   // Vector numbers
   localparam int VEC_RESET = 0;
   localparam int VEC_NMI = 1;
   localparam int VEC_VLM = 2;
   localparam int VEC_PORT_A = 3;
   localparam int VEC_RTC_COUNTER_REQ = 6;
   localparam int VEC_PERIODIC_TIMER_REQ = 7;
   localparam int VEC_TA_OVF = 8;
   localparam int VEC_TA_HUNF = 9;
   localparam int VEC_TA_CMP0 = 10;
   localparam int VEC_TB = 13;
   localparam int VEC_TD_OVF = 14;
   localparam int VEC_TD_TRIG = 15;
   localparam int VEC_AC = 16;
   localparam int VEC_ADC_RES = 17;
   localparam int VEC_ADC_WCMP = 18;
   localparam int VEC_TWI_TGT = 19;
   localparam int VEC_TWI_CTL = 20;
   localparam int VEC_SPI = 21;
   localparam int VEC_SER_RXC = 22;
   localparam int VEC_SER_DRE = 23;
   localparam int VEC_SER_TXC = 24;
   localparam int VEC_NVM = 25;
   localparam logic [25:0] FLAG_RESET = 26'h0000000;
   localparam logic [25:0] ENABLE_RESET = 26'h0000000;
   // Block status events
   localparam int IRQ_W = 2;
   localparam int IRQ_NMI_BIT = 0;
   localparam int IRQ_REQ_BIT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage : ivm_pkg

// *** verification/event_source_model.sv ***
`timescale 1ns/100ps
module event_source_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Command from the bench
   input wire logic fire,
   input wire logic [4:0] fire_idx,
   // Peripheral event lines, index 26 is the timer A low-half underflow
   output logic [26:0] ev
);
   // Peripherals report one-cycle pulses, the shortest event a source may give
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ev <= 27'h0000000;
      end else begin
         ev <= fire ? (27'h0000001 << fire_idx) : 27'h0000000;
      end
   end
endmodule : event_source_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h00000000;
   logic [31:0] wb_rdata;
   logic [31:0] rd_dat;
   logic wb_ack;
   logic fire = 1'b0;
   logic [4:0] fire_idx = 5'h00;
   logic [26:0] ev;
   logic core_req;
   logic core_nmi;
   logic [4:0] core_vector;
   logic irq;
   logic [31:0] core_view;
   int n_errors = 0;
   int total_checks = 0;

   always #2 core_clk = ~core_clk;
   // Same layout as the vector register, so one expectation serves both
   assign core_view = {22'h000000, core_nmi, core_req, 3'h0, core_vector};

   event_source_model i_src (.core_clk(core_clk), .arst_n(arst_n), .fire(fire),
      .fire_idx(fire_idx), .ev(ev));

   interrupt_vector_mapper i_dut (.core_clk(core_clk), .arst_n(arst_n),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdata), .wb_ack_o(wb_ack),
      .scan_checksum_nonmaskable(ev[1]), .voltage_level_monitor_req(ev[2]),
      .port_a_pin_change_req(ev[3]), .port_b_pin_change_req(ev[4]),
      .port_c_pin_change_req(ev[5]), .rtc_counter_req(ev[6]), .periodic_timer_req(ev[7]),
      .timer_a_overflow(ev[8]), .timer_a_low_underflow(ev[26]),
      .timer_a_high_underflow(ev[9]), .timer_a_compare_0(ev[10]),
      .timer_a_compare_1(ev[11]), .timer_a_compare_2(ev[12]), .timer_b_req(ev[13]),
      .timer_d_overflow(ev[14]), .timer_d_trigger(ev[15]), .comparator_req(ev[16]),
      .converter_result_ready(ev[17]), .converter_window_compare(ev[18]),
      .two_wire_target_req(ev[19]), .two_wire_controller_req(ev[20]),
      .serial_peripheral_req(ev[21]), .serial_receive_complete(ev[22]),
      .serial_data_reg_empty(ev[23]), .serial_transmit_complete(ev[24]),
      .nonvolatile_ready_req(ev[25]), .core_req(core_req), .core_nmi(core_nmi),
      .core_vector(core_vector), .irq(irq));

   task automatic conclude;
      $display("Checks made: %0d, mismatches: %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] exp_core(input logic req, input logic nmi, input int vec);
      return {22'h000000, nmi, req, 3'h0, 5'(vec)};
   endfunction : exp_core

   // Classic single cycle; the request holds until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hF;
      wb_dat <= dat;
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge core_clk);
      end while (wb_ack !== 1'b1);
      rd_dat = wb_rdata;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask : wb_xfer

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
      wb_xfer(1'b0, adr, 32'h00000000);
      check(rd_dat, exp, what);
   endtask : rd

   task automatic settle;
      repeat (3) @(posedge core_clk);
   endtask : settle

   task automatic fire_ev(input int idx);
      @(posedge core_clk);
      fire <= 1'b1;
      fire_idx <= 5'(idx);
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : fire_ev

   task automatic t_reset;
      rd(ivm_pkg::OFS_CONTROL, 32'h00000000, "control reset");
      rd(ivm_pkg::OFS_EVENT_FLAG, 32'h00000000, "flag reset");
      rd(8'h40, 32'h00000000, "unmapped read");
      check(core_view, 32'h00000000, "core idle");
      check({31'h00000000, irq}, 32'h00000000, "irq idle");
   endtask : t_reset

   task automatic t_map;
      logic [31:0] bit_v;
      int ev_v;
      wb_xfer(1'b1, ivm_pkg::OFS_CONTROL, 32'h00000001);
      wb_xfer(1'b1, ivm_pkg::OFS_SOURCE_ENABLE, 32'hFFFFFFFF);
      rd(ivm_pkg::OFS_SOURCE_ENABLE, 32'h03FFFFFE, "enable bits");
      for (int v = 1; v < 27; v++) begin
         if (v == 26)
            wb_xfer(1'b1, ivm_pkg::OFS_CONTROL, 32'h00000003);
         ev_v = (v == 26) ? ivm_pkg::VEC_TA_OVF : v;
         bit_v = 32'h00000001 << ev_v;
         fire_ev(v);
         rd(ivm_pkg::OFS_EVENT_FLAG, bit_v, "flag set");
         check(core_view, exp_core(1'b1, ev_v == 1, ev_v), "mapping");
         rd(ivm_pkg::OFS_VECTOR, exp_core(1'b1, ev_v == 1, ev_v), "vector reg");
         wb_xfer(1'b1, ivm_pkg::OFS_EVENT_FLAG, bit_v);
         settle();
         check(core_view, 32'h00000000, "cleared");
      end
      // Split mode must ignore the plain overflow line
      fire_ev(ivm_pkg::VEC_TA_OVF);
      rd(ivm_pkg::OFS_EVENT_FLAG, 32'h00000000, "split overflow");
      wb_xfer(1'b1, ivm_pkg::OFS_CONTROL, 32'h00000001);
      // Plain mode must ignore the low-half underflow line
      fire_ev(26);
      rd(ivm_pkg::OFS_EVENT_FLAG, 32'h00000000, "plain underflow");
   endtask : t_map

   task automatic t_prio;
      fire_ev(20);
      fire_ev(5);
      check(core_view, exp_core(1'b1, 1'b0, 5), "lowest first");
      repeat (10) @(posedge core_clk);
      check(core_view, exp_core(1'b1, 1'b0, 5), "request holds");
      wb_xfer(1'b1, ivm_pkg::OFS_EVENT_FLAG, 32'h00000020);
      settle();
      check(core_view, exp_core(1'b1, 1'b0, 20), "next vector");
      wb_xfer(1'b1, ivm_pkg::OFS_EVENT_FLAG, 32'h00100000);
   endtask : t_prio

   task automatic t_gate;
      wb_xfer(1'b1, ivm_pkg::OFS_SOURCE_ENABLE, 32'h00000000);
      fire_ev(13);
      rd(ivm_pkg::OFS_EVENT_FLAG, 32'h00002000, "flag while disabled");
      rd(ivm_pkg::OFS_PENDING, 32'h00000000, "pending disabled");
      check(core_view, 32'h00000000, "no request disabled");
      wb_xfer(1'b1, ivm_pkg::OFS_SOURCE_ENABLE, 32'h00002002);
      settle();
      check(core_view, exp_core(1'b1, 1'b0, 13), "enabled late");
      wb_xfer(1'b1, ivm_pkg::OFS_CONTROL, 32'h00000000);
      settle();
      check(core_view, 32'h00000000, "global off");
      fire_ev(1);
      check(core_view, exp_core(1'b1, 1'b1, 1), "nmi ignores global");
      wb_xfer(1'b1, ivm_pkg::OFS_EVENT_FLAG, 32'h00002002);
      wb_xfer(1'b1, ivm_pkg::OFS_CONTROL, 32'h00000001);
   endtask : t_gate

   task automatic t_irq;
      wb_xfer(1'b1, ivm_pkg::OFS_SOURCE_ENABLE, 32'h03FFFFFE);
      wb_xfer(1'b1, ivm_pkg::OFS_IRQ_CLEAR, 32'h00000003);
      wb_xfer(1'b1, ivm_pkg::OFS_IRQ_ENABLE, 32'h00000002);
      rd(ivm_pkg::OFS_IRQ_STATUS, 32'h00000000, "status cleared");
      fire_ev(22);
      rd(ivm_pkg::OFS_IRQ_STATUS, 32'h00000002, "request event");
      wb_xfer(1'b1, ivm_pkg::OFS_EVENT_FLAG, 32'h00400000);
      settle();
      check({31'h00000000, irq}, 32'h00000001, "irq sticky");
      wb_xfer(1'b1, ivm_pkg::OFS_IRQ_ENABLE, 32'h00000000);
      settle();
      check({31'h00000000, irq}, 32'h00000000, "irq masked");
      wb_xfer(1'b1, ivm_pkg::OFS_IRQ_ENABLE, 32'h00000001);
      wb_xfer(1'b1, ivm_pkg::OFS_IRQ_CLEAR, 32'h00000002);
      fire_ev(1);
      check({31'h00000000, irq}, 32'h00000001, "nmi irq");
      rd(ivm_pkg::OFS_IRQ_STATUS, 32'h00000003, "nmi event");
      wb_xfer(1'b1, ivm_pkg::OFS_EVENT_FLAG, 32'h00000002);
      wb_xfer(1'b1, ivm_pkg::OFS_IRQ_CLEAR, 32'h00000003);
      settle();
      check({31'h00000000, irq}, 32'h00000000, "irq cleared");
   endtask : t_irq

   // Whole sequence needs well under a thousand cycles; this span is far beyond it
   initial begin
      #100000;
      n_errors++;
      conclude();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset();
      t_map();
      t_prio();
      t_gate();
      t_irq();
      conclude();
   end
endmodule : tb_top
